// ===== adc_mode_control_pkg.sv
// constants, field layouts and states of the converter mode control block
// assumes 8-bit registers in the low lane of a 32-bit classic Wishbone bus

package adc_mode_control_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_MODE   = 16'hFF80;
    localparam logic [15:0] ADDR_RESULT = 16'hFF88;
    localparam logic [15:0] ADDR_STATUS = 16'hFF8C;
    localparam logic [15:0] ADDR_MASK   = 16'hFF90;
    localparam logic [15:0] ADDR_OSC    = 16'hFF94;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] OSC_RESET  = 8'h00;
    localparam logic [7:0] ZERO8      = 8'h00;

    // ----------------------------------------------------------------
    // field positions and codes
    // ----------------------------------------------------------------
    localparam int DONE_BIT   = 0;
    localparam int BYPASS_BIT = 0;

    // conversion time codes {hi, lo, low bit}
    localparam logic [2:0] TIME_80  = 3'h1;
    localparam logic [2:0] TIME_40  = 3'h3;
    localparam logic [2:0] TIME_50  = 3'h4;
    localparam logic [2:0] TIME_100 = 3'h5;

    // a conversion is ten slots: two sampling, eight bit decisions
    localparam logic [3:0] SLOTS      = 4'hA;
    localparam logic [3:0] LAST_SLOT  = 4'h9;
    localparam logic [3:0] LAST_SAMPLE = 4'h1;
    // slot lengths in converter clocks (total / ten)
    localparam logic [3:0] SLOT_80  = 4'h8;
    localparam logic [3:0] SLOT_40  = 4'h4;
    localparam logic [3:0] SLOT_50  = 4'h5;
    localparam logic [3:0] SLOT_100 = 4'hA;

    localparam logic [7:0] MSB_TRIAL = 8'h80;

    // mode register layout
    typedef struct packed {
        logic       run;                    // bit 7
        logic       hardware_trigger_select; // bit 6
        logic       conv_time_sel_hi;       // bit 5
        logic       conv_time_sel_lo;       // bit 4
        logic [2:0] channel_sel;            // bits 3..1
        logic       conv_time_sel_low_bit;  // bit 0
    } adc_mode_register_t;

    // gray along idle -> wait -> sample -> convert
    typedef enum logic [1:0] {
        ST_IDLE     = 2'h0,
        ST_TRIG     = 2'h1,
        ST_SAMPLE   = 2'h3,
        ST_CONVERT  = 2'h2
    } conv_state_t;

endpackage

// ===== adc_mode_control.sv
// converter mode control: Wishbone register file, conversion sequencer,
// successive-approximation register and done interrupt
// assumes an external DAC + comparator: CMP_I high when input >= DAC_O,
// settled within one converter slot; all inputs synchronous to CLK_I

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - eight-bit SAR result, eight input channels
// - single channel mode, optional external trigger
// - software mode repeats conversion continuously
// - mode bits 3..1 pick channel binary
// - time code sets conversion clock count
// - bit 6 selects software or trigger start
// - clearing bit 7 stops conversion
// - run bit starts; clear flag first
// - converter clock is oscillator or half

module adc_mode_control #(
    parameter int ADDR_W = 16,
    parameter int RES_W  = 8
) (
    input  wire logic              CLK_I,   // system clock, 100 MHz
    input  wire logic              SRST_I,  // synchronous reset, high
    input  wire logic              CYC_I,   // wishbone cycle
    input  wire logic              STB_I,   // wishbone strobe
    input  wire logic              WE_I,    // wishbone write enable
    input  wire logic [ADDR_W-1:0] ADR_I,   // wishbone byte address
    input  wire logic [3:0]        SEL_I,   // wishbone byte selects
    input  wire logic [31:0]       DAT_I,   // wishbone write data
    output logic      [31:0]       DAT_O,   // wishbone read data
    output logic                   ACK_O,   // wishbone acknowledge
    input  wire logic              TRIG_I,  // external start trigger
    input  wire logic              CMP_I,   // comparator result
    output logic      [RES_W-1:0]  DAC_O,   // trial code to the DAC
    output logic      [2:0]        CH_SEL_O, // analog channel select
    output logic                   SAMPLE_O, // sample/hold active
    output logic                   IRQ_O    // conversion done interrupt
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    initial begin
        if (ADDR_W < 16) begin
            $error("ADDR_W must be at least 16");
        end
        if (RES_W != 8) begin
            $error("RES_W must be 8");
        end
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    adc_mode_control_pkg::adc_mode_register_t mode_reg;
    adc_mode_control_pkg::conv_state_t        state_reg;
    adc_mode_control_pkg::conv_state_t        state_next;

    logic              ack_reg;
    logic [31:0]       rdata_reg;
    logic [7:0]        result_reg;
    logic [7:0]        status_reg;
    logic [7:0]        mask_reg;
    logic [7:0]        osc_reg;
    logic [7:0]        trial_reg;
    logic [7:0]        bit_reg;
    logic [2:0]        chan_reg;
    logic [3:0]        slot_reg;
    logic [3:0]        tick_reg;
    logic              div_reg;
    logic              trig_d_reg;

    logic              bus_req;
    logic              wr_now;
    logic              rd_now;
    logic              mode_wr;
    logic              status_rd;
    logic [15:0]       addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata_next;
    logic              conv_tick;
    logic              slot_end;
    logic              conv_done;
    logic              trig_rise;
    logic              active;
    logic [3:0]        slot_len;
    logic [2:0]        time_code;

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    assign addr    = ADR_I[15:0];
    assign wdata   = DAT_I[7:0];
    assign bus_req = CYC_I & STB_I;
    // writes land on the edge where the master sees ack high
    assign wr_now  = bus_req & ack_reg & WE_I & SEL_I[0];
    assign rd_now  = bus_req & ack_reg & ~WE_I;
    assign mode_wr = wr_now & (addr == adc_mode_control_pkg::ADDR_MODE);
    assign status_rd = rd_now & (addr == adc_mode_control_pkg::ADDR_STATUS);

    // one wait state, ack drops the cycle after it is given
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rdata_next = adc_mode_control_pkg::ZERO8;
        if (addr == adc_mode_control_pkg::ADDR_MODE) begin
            rdata_next = mode_reg;
        end else if (addr == adc_mode_control_pkg::ADDR_RESULT) begin
            rdata_next = result_reg;
        end else if (addr == adc_mode_control_pkg::ADDR_STATUS) begin
            rdata_next = status_reg;
        end else if (addr == adc_mode_control_pkg::ADDR_MASK) begin
            rdata_next = mask_reg;
        end else if (addr == adc_mode_control_pkg::ADDR_OSC) begin
            rdata_next = osc_reg;
        end
    end

    // read data captured in the request cycle, shown with ack
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req & ~ack_reg) begin
            rdata_reg <= {24'h00_0000, rdata_next};
        end
    end

    assign DAT_O = rdata_reg;
    assign ACK_O = ack_reg;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // mode register, all fields
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            mode_reg <= adc_mode_control_pkg::MODE_RESET;
        end else if (mode_wr) begin
            mode_reg <= wdata;
        end
    end

    // mask and oscillator divider bypass
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            mask_reg <= adc_mode_control_pkg::ZERO8;
            osc_reg  <= adc_mode_control_pkg::OSC_RESET;
        end else if (wr_now) begin
            if (addr == adc_mode_control_pkg::ADDR_MASK) begin
                mask_reg <= wdata;
            end else if (addr == adc_mode_control_pkg::ADDR_OSC) begin
                osc_reg <= wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // converter clock and timing
    // ----------------------------------------------------------------
    // full or half rate tick
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            div_reg <= 1'b0;
        end else begin
            div_reg <= active & ~div_reg;
        end
    end

    assign conv_tick = osc_reg[adc_mode_control_pkg::BYPASS_BIT] | div_reg;
    assign active    = (state_reg == adc_mode_control_pkg::ST_SAMPLE) |
                       (state_reg == adc_mode_control_pkg::ST_CONVERT);

    assign time_code = {mode_reg.conv_time_sel_hi, mode_reg.conv_time_sel_lo,
                        mode_reg.conv_time_sel_low_bit};

    // slot length per code
    // prohibited codes run at the slowest rate rather than hang
    always_comb begin
        case (time_code)
            adc_mode_control_pkg::TIME_80:  slot_len = adc_mode_control_pkg::SLOT_80;
            adc_mode_control_pkg::TIME_40:  slot_len = adc_mode_control_pkg::SLOT_40;
            adc_mode_control_pkg::TIME_50:  slot_len = adc_mode_control_pkg::SLOT_50;
            adc_mode_control_pkg::TIME_100: slot_len = adc_mode_control_pkg::SLOT_100;
            default:                        slot_len = adc_mode_control_pkg::SLOT_100;
        endcase
    end

    assign slot_end  = active & conv_tick & (tick_reg == slot_len - 4'h1);
    assign conv_done = slot_end & (state_reg == adc_mode_control_pkg::ST_CONVERT) &
                       (slot_reg == adc_mode_control_pkg::LAST_SLOT);

    // tick counter within a slot, slot counter within a conversion
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            tick_reg <= 4'h0;
            slot_reg <= 4'h0;
        end else if (~active | mode_wr | (state_next != state_reg &
                     state_next == adc_mode_control_pkg::ST_SAMPLE)) begin
            tick_reg <= 4'h0;
            slot_reg <= 4'h0;
        end else if (slot_end) begin
            tick_reg <= 4'h0;
            slot_reg <= slot_reg + 4'h1;
        end else if (conv_tick) begin
            tick_reg <= tick_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign trig_rise = TRIG_I & ~trig_d_reg;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            trig_d_reg <= 1'b0;
        end else begin
            trig_d_reg <= TRIG_I;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (mode_wr) begin
            // a mode write restarts from the new settings
            if (~wdata[7]) begin
                state_next = adc_mode_control_pkg::ST_IDLE;
            end else if (wdata[6]) begin
                state_next = adc_mode_control_pkg::ST_TRIG;
            end else begin
                state_next = adc_mode_control_pkg::ST_SAMPLE;
            end
        end else if (~mode_reg.run) begin
            state_next = adc_mode_control_pkg::ST_IDLE;
        end else if (mode_reg.hardware_trigger_select & trig_rise) begin
            // a trigger mid-conversion restarts it
            state_next = adc_mode_control_pkg::ST_SAMPLE;
        end else begin
            case (state_reg)
                adc_mode_control_pkg::ST_SAMPLE: begin
                    if (slot_end & slot_reg == adc_mode_control_pkg::LAST_SAMPLE) begin
                        state_next = adc_mode_control_pkg::ST_CONVERT;
                    end
                end
                adc_mode_control_pkg::ST_CONVERT: begin
                    if (conv_done) begin
                        if (mode_reg.hardware_trigger_select) begin
                            state_next = adc_mode_control_pkg::ST_TRIG;
                        end else begin
                            state_next = adc_mode_control_pkg::ST_SAMPLE;
                        end
                    end
                end
                adc_mode_control_pkg::ST_IDLE: begin
                    state_next = mode_reg.hardware_trigger_select ?
                                 adc_mode_control_pkg::ST_TRIG :
                                 adc_mode_control_pkg::ST_SAMPLE;
                end
                default: begin
                    state_next = adc_mode_control_pkg::ST_TRIG;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_reg <= adc_mode_control_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // channel latched at each start so a mid-run write cannot mix inputs
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            chan_reg <= 3'h0;
        end else if (state_next == adc_mode_control_pkg::ST_SAMPLE &
                     (state_reg != adc_mode_control_pkg::ST_SAMPLE | mode_wr)) begin
            chan_reg <= mode_wr ? wdata[3:1] : mode_reg.channel_sel;
        end
    end

    // ----------------------------------------------------------------
    // successive approximation
    // ----------------------------------------------------------------
    // binary search, msb first
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            trial_reg <= adc_mode_control_pkg::ZERO8;
            bit_reg   <= adc_mode_control_pkg::ZERO8;
        end else if (state_next == adc_mode_control_pkg::ST_SAMPLE &
                     state_reg != adc_mode_control_pkg::ST_SAMPLE) begin
            trial_reg <= adc_mode_control_pkg::ZERO8;
            bit_reg   <= adc_mode_control_pkg::ZERO8;
        end else if (slot_end & state_reg == adc_mode_control_pkg::ST_SAMPLE &
                     slot_reg == adc_mode_control_pkg::LAST_SAMPLE) begin
            trial_reg <= adc_mode_control_pkg::MSB_TRIAL;
            bit_reg   <= adc_mode_control_pkg::MSB_TRIAL;
        end else if (slot_end & state_reg == adc_mode_control_pkg::ST_CONVERT) begin
            // keep the bit if the input is not below the trial
            trial_reg <= (CMP_I ? trial_reg : (trial_reg & ~bit_reg)) | (bit_reg >> 1);
            bit_reg   <= bit_reg >> 1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            result_reg <= adc_mode_control_pkg::ZERO8;
        end else if (conv_done) begin
            result_reg <= CMP_I ? trial_reg : (trial_reg & ~bit_reg);
        end
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    // sticky done flag
    // a new completion wins over the read that clears the flag
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            status_reg <= adc_mode_control_pkg::ZERO8;
        end else begin
            status_reg[adc_mode_control_pkg::DONE_BIT] <=
                (status_reg[adc_mode_control_pkg::DONE_BIT] & ~status_rd) | conv_done;
        end
    end

    assign IRQ_O = |(status_reg & mask_reg);

    // ----------------------------------------------------------------
    // analog side outputs
    // ----------------------------------------------------------------
    assign DAC_O    = trial_reg;
    assign CH_SEL_O = chan_reg;
    assign SAMPLE_O = (state_reg == adc_mode_control_pkg::ST_SAMPLE);

endmodule

`default_nettype wire

// ===== adc_mode_control_monitor.sv
// checker for the converter mode control block: bus handshake, sequencer and interrupt
// assumes only the top module's ports; bound to every instance from the bench file
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_monitor #(
    parameter int ADDR_W = 16,
    parameter int RES_W  = 8
) (
    input wire logic              CLK_I,    // system clock
    input wire logic              SRST_I,   // synchronous reset
    input wire logic              CYC_I,    // bus cycle
    input wire logic              STB_I,    // bus strobe
    input wire logic              WE_I,     // bus write enable
    input wire logic [ADDR_W-1:0] ADR_I,    // bus address
    input wire logic [31:0]       DAT_O,    // bus read data
    input wire logic              ACK_O,    // bus acknowledge
    input wire logic              TRIG_I,   // external trigger
    input wire logic [RES_W-1:0]  DAC_O,    // trial code
    input wire logic [2:0]        CH_SEL_O, // converted channel
    input wire logic              SAMPLE_O, // sampling phase
    input wire logic              IRQ_O     // done interrupt
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    // one fixed wait state, a single-cycle ack, never unasked
    a_ack_latency: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("ack not one cycle after request");
    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_asked: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    a_read_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000)
        else $error("read data above the byte lane");

    // ----------------------------------------------------------------
    // sequencer and interrupt
    // ----------------------------------------------------------------
    // the channel may only move when a new sampling phase begins
    a_channel_hold: assert property ($changed(CH_SEL_O) |-> $rose(SAMPLE_O))
        else $error("channel changed outside conversion start");
    a_msb_trial: assert property ($fell(SAMPLE_O) |-> DAC_O == adc_mode_control_pkg::MSB_TRIAL)
        else $error("first trial is not the top bit");
    // status clears on the read's ack edge and the level output follows it
    a_irq_read_clear: assert property (ACK_O && !WE_I
        && ADR_I[15:0] == adc_mode_control_pkg::ADDR_STATUS |-> ##2 !IRQ_O)
        else $error("interrupt kept after status read");
    // reset must be checked while reset itself is high
    a_reset_quiet: assert property (disable iff (1'b0)
        SRST_I |=> !ACK_O && !IRQ_O && !SAMPLE_O && DAC_O == '0)
        else $error("outputs active after reset");

    c_done: cover property ($rose(IRQ_O));
    c_trig_start: cover property ($rose(TRIG_I) ##[1:3] $rose(SAMPLE_O));
    c_decide: cover property ($fell(SAMPLE_O));
endmodule
`default_nettype wire

// ===== adc_analog_model.sv
// analogue side: eight fixed input levels and a comparator against the trial code
// assumes the comparator settles well inside one converter slot
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
    input  wire logic [2:0] ch_sel_i, // channel being converted
    input  wire logic [7:0] dac_i,    // trial code
    output logic            cmp_o     // high when input >= trial
);
    // eight channel levels
    // levels run from 0x03 to 0xFF so that the top end of the code is hit
    function automatic logic [7:0] level(input logic [2:0] ch);
        return {5'h00, ch} * 8'h24 + 8'h03;
    endfunction

    assign cmp_o = level(ch_sel_i) >= dac_i;
endmodule
`default_nettype wire

// ===== adc_mode_control_bench.sv
// testbench: register bus tasks and scenarios for channel, time code, trigger, stop, mask
// assumes the analogue model on the comparator and the monitor bound at the foot
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_bench;
    localparam int ADDR_W = 16;
    logic        clk  = 1'b0;
    logic        srst = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic        trig = 1'b0;
    logic [15:0] adr  = 16'h0000;
    logic [3:0]  sel  = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic        ack, cmp, samp, irq;
    logic [7:0]  dac;
    logic [2:0]  ch;
    int          bad_count = 0;
    int          n_checks  = 0;

    always #5 clk = ~clk;

    adc_mode_control uut (.CLK_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .TRIG_I(trig),
        .CMP_I(cmp), .DAC_O(dac), .CH_SEL_O(ch), .SAMPLE_O(samp), .IRQ_O(irq));
    adc_analog_model far (.ch_sel_i(ch), .dac_i(dac), .cmp_o(cmp));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test;
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // expected input level, same spread as the analogue side
    function automatic logic [7:0] lvl(input logic [2:0] c);
        return {5'h00, c} * 8'h24 + 8'h03;
    endfunction

    // one classic cycle; only the watchdog ends a missing ack
    task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'h1;
        wdat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, {24'h000000, e});
    endtask

    // bounded wait for the sampling (s=1) or interrupt (s=0) output
    task automatic wait_for(input bit s, input logic v);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            if ((s ? samp : irq) === v) break;
        end
        chk(i < 3000, 1'b1);
    endtask

    task automatic pulse_trig;
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd_chk(adc_mode_control_pkg::ADDR_MODE, 8'h01);
        rd_chk(adc_mode_control_pkg::ADDR_STATUS, 8'h00);
        wr(16'hFF84, 8'hFF);
        rd_chk(16'hFF84, 8'h00);
        chk(samp, 1'b0);
    endtask

    // every channel by hardware start; no repeat without a new edge
    task automatic t_channels;
        logic [2:0] c;
        wr(adc_mode_control_pkg::ADDR_OSC, 8'h01);
        wr(adc_mode_control_pkg::ADDR_MASK, 8'h01);
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            wr(adc_mode_control_pkg::ADDR_MODE, {4'hC, c, 1'b1});
            repeat (20) @(posedge clk);
            chk(samp, 1'b0);
            pulse_trig();
            wait_for(1'b0, 1'b1);
            chk(ch, c);
            rd_chk(adc_mode_control_pkg::ADDR_RESULT, lvl(c));
            rd_chk(adc_mode_control_pkg::ADDR_STATUS, 8'h01);
            rd_chk(adc_mode_control_pkg::ADDR_STATUS, 8'h00);
            chk(samp, 1'b0);
        end
    endtask

    // sampling length and repeat period per time code, both clock rates
    task automatic t_times;
        logic [2:0] code [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
        int         tot [4]  = '{80, 40, 50, 100};
        int         n, p, m;
        for (int b = 1; b >= 0; b--) begin
            wr(adc_mode_control_pkg::ADDR_OSC, 8'(b));
            for (int k = 0; k < 4; k++) begin
                m = 2 - b;
                wr(adc_mode_control_pkg::ADDR_MODE, 8'h00);
                wr(adc_mode_control_pkg::ADDR_MODE, {2'b10, code[k][2:1], 3'h0, code[k][0]});
                wait_for(1'b1, 1'b1);
                n = 0;
                p = 0;
                while (samp === 1'b1 && p < 500) begin
                    @(posedge clk);
                    n++;
                    p++;
                end
                while (samp !== 1'b1 && p < 500) begin
                    @(posedge clk);
                    p++;
                end
                chk(n, tot[k] / 5 * m);
                chk(p >= tot[k] * m && p <= tot[k] * m + 3, 1'b1);
                wait_for(1'b1, 1'b0);
            end
        end
    endtask

    // stop in mid-conversion: old result kept, no flag, no sampling
    task automatic t_stop;
        logic [31:0] q;
        wr(adc_mode_control_pkg::ADDR_OSC, 8'h01);
        wr(adc_mode_control_pkg::ADDR_MODE, 8'h83);
        wait_for(1'b1, 1'b1);
        wait_for(1'b1, 1'b0);
        wr(adc_mode_control_pkg::ADDR_MODE, 8'h03);
        wb(1'b0, adc_mode_control_pkg::ADDR_STATUS, 8'h00, q);
        repeat (300) @(posedge clk);
        chk(samp, 1'b0);
        chk(irq, 1'b0);
        rd_chk(adc_mode_control_pkg::ADDR_STATUS, 8'h00);
        rd_chk(adc_mode_control_pkg::ADDR_RESULT, lvl(3'h0));
    endtask

    // mask holds the interrupt back while the flag stays set
    task automatic t_mask;
        wr(adc_mode_control_pkg::ADDR_MASK, 8'h00);
        wr(adc_mode_control_pkg::ADDR_MODE, 8'hC1);
        pulse_trig();
        wait_for(1'b1, 1'b1);
        wait_for(1'b1, 1'b0);
        repeat (100) @(posedge clk);
        chk(irq, 1'b0);
        wr(adc_mode_control_pkg::ADDR_MASK, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rd_chk(adc_mode_control_pkg::ADDR_MASK, 8'h01);
        rd_chk(adc_mode_control_pkg::ADDR_STATUS, 8'h01);
    endtask

    // main sequence, with a second reset after the scenarios
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_channels();
        t_times();
        t_stop();
        t_mask();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        finish_test();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule

bind adc_mode_control adc_mode_control_monitor #(.ADDR_W(ADDR_W), .RES_W(RES_W)) mon (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .TRIG_I(TRIG_I), .DAC_O(DAC_O),
    .CH_SEL_O(CH_SEL_O), .SAMPLE_O(SAMPLE_O), .IRQ_O(IRQ_O));
`default_nettype wire
